// ---- hdl/dipim_map.vh ----
// Register map, field positions, reset values and timing for the process image block.
`ifndef DIPIM_MAP_VH
`define DIPIM_MAP_VH

`define DIPIM_ADDR_W 6
`define DIPIM_OFS_IN_IMAGE 6'h00
`define DIPIM_OFS_OUT_IMAGE 6'h04
`define DIPIM_OFS_DIAG 6'h08
`define DIPIM_OFS_IRQ_STAT 6'h0C
`define DIPIM_OFS_IRQ_MASK 6'h10
`define DIPIM_OFS_CTRL 6'h14

`define DIPIM_OUT_RST 16'h0000
`define DIPIM_MASK_RST 32'h00000000
`define DIPIM_CTRL_RST 32'h00000000

// Diagnostic byte 0 (bits 15..8 of the diagnostic word).
`define DIPIM_DG_SENSOR_UV 15
`define DIPIM_DG_INIT_SUPPLY 14
`define DIPIM_DG_SUPPLY_24V 13
`define DIPIM_DG_COMM_UV 12
// Diagnostic byte 1 (bits 7..0 of the diagnostic word).
`define DIPIM_DG_IO_UNCONF 3
`define DIPIM_DG_ERR_HANDLING 2
`define DIPIM_DG_TYPE_UNKNOWN 1
`define DIPIM_DG_SHORT_CIRCUIT 0
`define DIPIM_DG_VALID_MASK 16'hF00F

// Interrupt status bits.
`define DIPIM_IRQ_DIAG_RISE 0
`define DIPIM_IRQ_IN_CHANGE 1
`define DIPIM_IRQ_OUT_APPLIED 2
`define DIPIM_IRQ_W 3

// Control bits.
`define DIPIM_CTRL_FREEZE_IN 0

`define DIPIM_RESP_OKAY 2'b00
`define DIPIM_RESP_SLVERR 2'b10

`define DIPIM_CLK_NS 50

`endif

// ---- hdl/dipim_slot_map.v ----
// Maps sixteen per-slot signals to and from the big-endian process word.
`timescale 1ns/1ps
module dipim_slot_map #(
    parameter SLOTS = 4
) (
    input wire [4*SLOTS-1:0] slot_bits, // Slot-ordered nibbles, slot a lowest
    output wire [4*SLOTS-1:0] word_bits // Process word, bit 15 is byte 0 bit 7
);
    // Word nibble order, high to low: slot b, slot a, slot d, slot c.
    // Within a nibble bit 3..0 is terminal 2.4, 1.4, 2.1, 1.1 and LED 4..1.
    genvar g;
    generate
        for (g = 0; g < SLOTS; g = g + 1) begin : g_nib
            localparam integer SRC = (g == 0) ? 2 : (g == 1) ? 3 :
                                     (g == 2) ? 0 : 1;
            assign word_bits[4*g+3:4*g] = slot_bits[4*SRC+3:4*SRC];
        end
    endgenerate
endmodule // dipim_slot_map

// ---- hdl/dipim_irq.v ----
// Sticky interrupt status with write-one-to-clear and a mask.
`timescale 1ns/1ps
`include "dipim_map.vh"
module dipim_irq #(
    parameter W = `DIPIM_IRQ_W
) (
    input wire aclk, // Clock
    input wire aresetn, // Synchronous reset, active low
    input wire [W-1:0] event_set, // One-cycle event pulses
    input wire [W-1:0] clear_bits, // Write-one-to-clear pulses
    input wire [W-1:0] mask, // Enable per status bit
    output reg [W-1:0] status_r, // Sticky status
    output reg irq_r // Level interrupt
);
    wire [W-1:0] status_nxt;
    // An event in the clearing cycle survives the clear.
    assign status_nxt = (status_r & ~clear_bits) | event_set;

    always @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= {W{1'b0}};
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r <= |(status_nxt & mask);
        end
    end
endmodule // dipim_irq

// ---- hdl/dipim_top.v ----
// Digital I/O process image with diagnostic word and AXI4-Lite registers.
`timescale 1ns/1ps
`include "dipim_map.vh"
module dipim_top #(
    parameter AW = `DIPIM_ADDR_W
) (
    input wire aclk, // Clock, 20 MHz
    input wire aresetn, // Synchronous reset, active low
    input wire [AW-1:0] s_axi_awaddr, // Write address
    input wire [2:0] s_axi_awprot, // Write protection, unused
    input wire s_axi_awvalid, // Write address valid
    output reg s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write byte strobes
    input wire s_axi_wvalid, // Write data valid
    output reg s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [AW-1:0] s_axi_araddr, // Read address
    input wire [2:0] s_axi_arprot, // Read protection, unused
    input wire s_axi_arvalid, // Read address valid
    output reg s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire [15:0] input_slots, // Inputs: [3:0] slot a .. [15:12] slot d
    output reg [15:0] output_slots, // Outputs: [3:0] slot a .. slot d
    output reg [15:0] output_leds, // Output indicators, same order
    output reg [15:0] input_leds, // Input indicators, same order
    input wire sensor_supply_uv, // Sensor supply undervoltage
    input wire initiator_supply_fault, // Initiator supply fault
    input wire supply_24v_fault, // 24 V supply fault
    input wire logic_comm_power_uv, // Communications power undervoltage
    input wire io_unconfigured, // I/O not configured or unknown
    input wire error_handling_active, // Error handling active
    input wire module_type_unknown, // Module type unknown
    input wire output_short, // Digital output short circuit
    output reg irq // Level interrupt, unmasked status set
);
    localparam [`DIPIM_IRQ_W-1:0] IRQ_ZERO = 3'h0;

    reg [15:0] out_word_r;
    reg [15:0] in_word_r;
    reg [15:0] diag_r;
    reg [15:0] in_slots_r;
    reg [`DIPIM_IRQ_W-1:0] mask_r;
    reg [31:0] ctrl_r;
    reg [AW-1:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg aw_held_r;
    reg w_held_r;
    reg out_applied_r;
    reg [15:0] in_word_prev_r;
    reg [15:0] diag_prev_r;
    reg [`DIPIM_IRQ_W-1:0] clear_nxt;
    reg [`DIPIM_IRQ_W-1:0] event_nxt;
    reg [31:0] rd_nxt;
    reg [1:0] rresp_nxt;
    wire [15:0] in_word_nxt;
    wire [15:0] out_slots_nxt;
    wire [15:0] diag_nxt;
    wire [15:0] readback_word;
    wire [`DIPIM_IRQ_W-1:0] irq_status;
    wire irq_level;
    wire wr_fire;
    wire rd_fire;
    wire [AW-1:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;

    dipim_slot_map #(
        .SLOTS(4)
    ) u_in_map (
        .slot_bits(in_slots_r),
        .word_bits(in_word_nxt)
    );

    // output slot order
    // The permutation swaps nibble pairs, so it is its own inverse.
    dipim_slot_map #(
        .SLOTS(4)
    ) u_out_map (
        .slot_bits(out_word_r),
        .word_bits(out_slots_nxt)
    );

    // readback of applied outputs
    // Readback is taken from the output pins rather than the written word,
    // so software sees a value only once it actually drives the terminals.
    // The same nibble swap turns the slot order back into word order.
    dipim_slot_map #(
        .SLOTS(4)
    ) u_rb_map (
        .slot_bits(output_slots),
        .word_bits(readback_word)
    );

    assign diag_nxt = {sensor_supply_uv, initiator_supply_fault,
                       supply_24v_fault, logic_comm_power_uv,
                       8'h00,
                       io_unconfigured, error_handling_active,
                       module_type_unknown, output_short};

    // Write address and data may arrive in either order; each is held
    // until both are present, then the register is written once.
    assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
    assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
    assign wr_fire = (aw_held_r | (s_axi_awvalid & s_axi_awready)) &
                     (w_held_r | (s_axi_wvalid & s_axi_wready)) &
                     ~s_axi_bvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;

    always @* begin
        clear_nxt = IRQ_ZERO;
        if (wr_fire && wr_addr == `DIPIM_OFS_IRQ_STAT && wr_strb[0]) begin
            clear_nxt = wr_data[`DIPIM_IRQ_W-1:0];
        end
        event_nxt = IRQ_ZERO;
        event_nxt[`DIPIM_IRQ_DIAG_RISE] = |(diag_r & ~diag_prev_r);
        event_nxt[`DIPIM_IRQ_IN_CHANGE] = |(in_word_r ^ in_word_prev_r);
        event_nxt[`DIPIM_IRQ_OUT_APPLIED] = out_applied_r;
    end

    dipim_irq #(
        .W(`DIPIM_IRQ_W)
    ) u_irq (
        .aclk(aclk),
        .aresetn(aresetn),
        .event_set(event_nxt),
        .clear_bits(clear_nxt),
        .mask(mask_r),
        .status_r(irq_status),
        .irq_r(irq_level)
    );

    // Read mux; unmapped offsets answer SLVERR with zero data.
    always @* begin
        rd_nxt = 32'h00000000;
        rresp_nxt = `DIPIM_RESP_OKAY;
        case (s_axi_araddr)
            `DIPIM_OFS_IN_IMAGE: begin
                rd_nxt = {readback_word, in_word_r};
            end
            `DIPIM_OFS_OUT_IMAGE: begin
                rd_nxt = {16'h0000, out_word_r};
            end
            `DIPIM_OFS_DIAG: begin
                rd_nxt = {16'h0000, diag_r};
            end
            `DIPIM_OFS_IRQ_STAT: begin
                rd_nxt = {29'h00000000, irq_status};
            end
            `DIPIM_OFS_IRQ_MASK: begin
                rd_nxt = {29'h00000000, mask_r};
            end
            `DIPIM_OFS_CTRL: begin
                rd_nxt = ctrl_r;
            end
            default: begin
                rresp_nxt = `DIPIM_RESP_SLVERR;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DIPIM_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `DIPIM_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= {AW{1'b0}};
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            out_word_r <= `DIPIM_OUT_RST;
            mask_r <= IRQ_ZERO;
            ctrl_r <= `DIPIM_CTRL_RST;
            out_applied_r <= 1'b0;
        end else begin
            out_applied_r <= 1'b0;
            s_axi_awready <= ~aw_held_r & ~s_axi_awready &
                             ~(s_axi_awvalid & s_axi_awready) &
                             ~s_axi_bvalid & s_axi_awvalid;
            s_axi_wready <= ~w_held_r & ~s_axi_wready &
                            ~(s_axi_wvalid & s_axi_wready) &
                            ~s_axi_bvalid & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `DIPIM_RESP_OKAY;
                case (wr_addr)
                    `DIPIM_OFS_OUT_IMAGE: begin
                        if (wr_strb[0]) begin
                            out_word_r[7:0] <= wr_data[7:0];
                        end
                        if (wr_strb[1]) begin
                            out_word_r[15:8] <= wr_data[15:8];
                        end
                        out_applied_r <= wr_strb[0] | wr_strb[1];
                    end
                    `DIPIM_OFS_IRQ_MASK: begin
                        if (wr_strb[0]) begin
                            mask_r <= wr_data[`DIPIM_IRQ_W-1:0];
                        end
                    end
                    `DIPIM_OFS_CTRL: begin
                        if (wr_strb[0]) begin
                            ctrl_r[0] <= wr_data[`DIPIM_CTRL_FREEZE_IN];
                        end
                    end
                    `DIPIM_OFS_IRQ_STAT, `DIPIM_OFS_IN_IMAGE,
                    `DIPIM_OFS_DIAG: begin
                        s_axi_bresp <= `DIPIM_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `DIPIM_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_nxt;
                s_axi_rresp <= rresp_nxt;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Process-side registers: sampled inputs, diagnostics, pins.
    always @(posedge aclk) begin
        if (!aresetn) begin
            in_slots_r <= 16'h0000;
            in_word_r <= 16'h0000;
            in_word_prev_r <= 16'h0000;
            diag_r <= 16'h0000;
            diag_prev_r <= 16'h0000;
            output_slots <= 16'h0000;
            output_leds <= 16'h0000;
            input_leds <= 16'h0000;
            irq <= 1'b0;
        end else begin
            // inputs refreshed
            // Freeze holds a consistent snapshot while software reads it.
            if (!ctrl_r[`DIPIM_CTRL_FREEZE_IN]) begin
                in_slots_r <= input_slots;
                in_word_r <= in_word_nxt;
            end
            in_word_prev_r <= in_word_r;
            diag_r <= diag_nxt & `DIPIM_DG_VALID_MASK;
            diag_prev_r <= diag_r;
            output_slots <= out_slots_nxt;
            output_leds <= out_slots_nxt;
            input_leds <= input_slots;
            irq <= irq_level;
        end
    end
endmodule // dipim_top

// ---- bench/dipim_checker.sv ----
// Port checks for the process image block.
`timescale 1ns/1ps
`include "dipim_map.vh"
module dipim_checker #(
    parameter AW = `DIPIM_ADDR_W
) (
    input wire aclk, // clock
    input wire aresetn, // reset, low
    input wire [AW-1:0] s_axi_awaddr, // aw addr
    input wire s_axi_awvalid, // aw valid
    input wire s_axi_awready, // aw ready
    input wire [31:0] s_axi_wdata, // w data
    input wire [3:0] s_axi_wstrb, // w strobes
    input wire s_axi_wvalid, // w valid
    input wire s_axi_wready, // w ready
    input wire s_axi_bvalid, // b valid
    input wire [AW-1:0] s_axi_araddr, // ar addr
    input wire s_axi_arvalid, // ar valid
    input wire s_axi_arready, // ar ready
    input wire [31:0] s_axi_rdata, // r data
    input wire [1:0] s_axi_rresp, // r resp
    input wire s_axi_rvalid, // r valid
    input wire [15:0] input_slots, // inputs
    input wire [15:0] output_slots, // outputs
    input wire [15:0] output_leds, // out leds
    input wire [15:0] input_leds, // in leds
    input wire irq // interrupt
);
    function automatic [15:0] swp(input [31:0] w);
        swp = {w[7:4], w[3:0], w[15:12], w[11:8]};
    endfunction
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire out_wr = aw_hs && w_hs && s_axi_wstrb == 4'hF &&
        s_axi_awaddr == `DIPIM_OFS_OUT_IMAGE;
    wire in_rd = ar_hs && s_axi_araddr == `DIPIM_OFS_IN_IMAGE;
    wire bad_rd = ar_hs && s_axi_araddr == 6'h3C;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_in_led;
        $past(aresetn) |-> input_leds == $past(input_slots);
    endproperty
    a_out_leds: assert property (
        out_wr |-> ##2 output_leds == swp($past(s_axi_wdata, 2)))
        else $error("output indicators differ from written word");
    a_in_leds: assert property (p_in_led)
        else $error("input indicators lag wrongly");
    a_b_after_w: assert property (aw_hs && w_hs |=> s_axi_bvalid)
        else $error("write response late");
    a_no_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while response pending");
    a_r_after_ar: assert property (ar_hs |=> s_axi_rvalid)
        else $error("read data late");
    a_no_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_out_apply: assert property (
        out_wr |-> ##2 output_slots == swp($past(s_axi_wdata, 2)))
        else $error("outputs do not follow written word");
    a_readback_word: assert property (
        in_rd |=> s_axi_rdata[31:16] == swp(output_slots))
        else $error("readback half differs from outputs");
    a_bad_read: assert property (
        bad_rd |=> s_axi_rresp == `DIPIM_RESP_SLVERR && s_axi_rdata == 0)
        else $error("unmapped read not refused");
    c_out_write: cover property (out_wr);
    c_bad_read: cover property (bad_rd);
    c_irq: cover property ($rose(irq));
endmodule // dipim_checker

bind dipim_top dipim_checker #(.AW(AW)) u_chk (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .input_slots, .output_slots,
    .output_leds, .input_leds, .irq);

// ---- bench/dipim_master.sv ----
// Register bus master model exchanging process data with the block.
`timescale 1ns/1ps
module dipim_master (
    input wire aclk, // clock
    output reg [5:0] s_axi_awaddr, // aw addr
    output reg s_axi_awvalid, // aw valid
    input wire s_axi_awready, // aw ready
    output reg [31:0] s_axi_wdata, // w data
    output reg s_axi_wvalid, // w valid
    input wire s_axi_wready, // w ready
    input wire [1:0] s_axi_bresp, // b resp
    input wire s_axi_bvalid, // b valid
    output reg s_axi_bready, // b ready
    output reg [5:0] s_axi_araddr, // ar addr
    output reg s_axi_arvalid, // ar valid
    input wire s_axi_arready, // ar ready
    input wire [31:0] s_axi_rdata, // r data
    input wire [1:0] s_axi_rresp, // r resp
    input wire s_axi_rvalid, // r valid
    output reg s_axi_rready // r ready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
    end
    // Released payload is inverted so stale values cannot pass.
    task automatic wr(input [5:0] a, input [31:0] d, output [1:0] r);
        reg aw_ok;
        reg w_ok;
        @(posedge aclk);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awready && !aw_ok) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wready && !w_ok) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input [5:0] a, output [31:0] d, output [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        while (!s_axi_rvalid) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule // dipim_master

// ---- bench/dipim_top_test.sv ----
// Self-checking bench for the process image block.
`timescale 1ns/1ps
`include "dipim_map.vh"
module dipim_top_test;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [15:0] input_slots = 16'h0000;
    reg [7:0] dg = 8'h00;
    wire [5:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    wire s_axi_rvalid, s_axi_rready, irq;
    wire [15:0] output_slots, output_leds, input_leds;
    integer err_count = 0;
    integer comparisons = 0;
    integer i;
    reg [31:0] rv;
    reg [1:0] rs;
    reg [39:0] rows [0:7];
    always #(`DIPIM_CLK_NS / 2) aclk = ~aclk;
    dipim_master m (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    dipim_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .input_slots, .output_slots, .output_leds,
        .input_leds, .sensor_supply_uv(dg[7]), .initiator_supply_fault(dg[6]),
        .supply_24v_fault(dg[5]), .logic_comm_power_uv(dg[4]),
        .io_unconfigured(dg[3]), .error_handling_active(dg[2]),
        .module_type_unknown(dg[1]), .output_short(dg[0]), .irq);
    function automatic [15:0] swp(input [15:0] w);
        swp = {w[7:4], w[3:0], w[15:12], w[11:8]};
    endfunction
    task check(input string name, input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, got);
        end
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        err_count = err_count + 1;
        final_report;
    end
    initial begin
        rows[0] = {16'h000F, 16'h8001, 8'h80};
        rows[1] = {16'h00F0, 16'h0F00, 8'h40};
        rows[2] = {16'h0F00, 16'h00F0, 8'h20};
        rows[3] = {16'hF000, 16'h000F, 8'h10};
        rows[4] = {16'h8001, 16'hF000, 8'h08};
        rows[5] = {16'h1248, 16'h1234, 8'h04};
        rows[6] = {16'hFFFF, 16'hC3A5, 8'h02};
        rows[7] = {16'h5A3C, 16'hFFFF, 8'h01};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        m.rd(`DIPIM_OFS_OUT_IMAGE, rv, rs);
        check("out image", rv, `DIPIM_OUT_RST);
        check("outputs", output_slots, 32'h0);
        m.rd(`DIPIM_OFS_IRQ_MASK, rv, rs);
        check("mask", rv, `DIPIM_MASK_RST);
        $display("reset test done");
        for (i = 0; i < 8; i = i + 1) begin
            input_slots <= rows[i][39:24];
            dg <= rows[i][7:0];
            m.wr(`DIPIM_OFS_OUT_IMAGE, {16'hFFFF, rows[i][23:8]}, rs);
            check("wr resp", rs, `DIPIM_RESP_OKAY);
            repeat (3) @(posedge aclk);
            check("outputs", output_slots, swp(rows[i][23:8]));
            check("out leds", output_leds, swp(rows[i][23:8]));
            check("in leds", input_leds, rows[i][39:24]);
            m.rd(`DIPIM_OFS_IN_IMAGE, rv, rs);
            check("in image", rv, {rows[i][23:8], swp(rows[i][39:24])});
            m.rd(`DIPIM_OFS_DIAG, rv, rs);
            check("diag", rv, {rows[i][7:4], 8'h00, rows[i][3:0]});
            check("diag lo", rv[7:0], {4'h0, rows[i][3:0]});
        end
        $display("table test done");
        m.rd(`DIPIM_OFS_OUT_IMAGE, rv, rs);
        check("reserved", rv, {16'h0000, rows[7][23:8]});
        m.wr(`DIPIM_OFS_IN_IMAGE, 32'h0, rs);
        check("ro wr", rs, `DIPIM_RESP_OKAY);
        m.rd(6'h3C, rv, rs);
        check("bad rd", rs, `DIPIM_RESP_SLVERR);
        check("bad rd data", rv, 32'h0);
        m.wr(6'h3C, 32'h0, rs);
        check("bad wr", rs, `DIPIM_RESP_SLVERR);
        check("kept", output_slots, swp(rows[7][23:8]));
        m.rd(`DIPIM_OFS_IN_IMAGE, rv, rs);
        check("ro kept", rv, {rows[7][23:8], swp(rows[7][39:24])});
        $display("bus error test done");
        m.wr(`DIPIM_OFS_IRQ_STAT, 32'h7, rs);
        m.wr(`DIPIM_OFS_IRQ_MASK, 32'h4, rs);
        m.wr(`DIPIM_OFS_OUT_IMAGE, 32'h5AA5, rs);
        repeat (4) @(posedge aclk);
        check("irq on", irq, 32'h1);
        m.rd(`DIPIM_OFS_IRQ_STAT, rv, rs);
        check("irq stat", rv, 32'h4);
        m.rd(`DIPIM_OFS_IN_IMAGE, rv, rs);
        check("readback", rv[31:16], 32'h5AA5);
        m.wr(`DIPIM_OFS_IRQ_STAT, 32'h4, rs);
        repeat (3) @(posedge aclk);
        check("irq clr", irq, 32'h0);
        m.rd(`DIPIM_OFS_IRQ_STAT, rv, rs);
        check("stat clr", rv, 32'h0);
        m.wr(`DIPIM_OFS_IRQ_MASK, 32'h0, rs);
        m.wr(`DIPIM_OFS_OUT_IMAGE, 32'h1111, rs);
        repeat (4) @(posedge aclk);
        check("irq mask", irq, 32'h0);
        m.wr(`DIPIM_OFS_IRQ_STAT, 32'h7, rs);
        input_slots <= 16'h0001;
        dg <= 8'h80;
        repeat (4) @(posedge aclk);
        m.rd(`DIPIM_OFS_IRQ_STAT, rv, rs);
        check("irq events", rv, 32'h3);
        dg <= 8'h00;
        m.rd(`DIPIM_OFS_DIAG, rv, rs);
        check("diag clear", rv, 32'h0);
        $display("irq test done");
        m.wr(`DIPIM_OFS_CTRL, 32'h1, rs);
        m.rd(`DIPIM_OFS_CTRL, rv, rs);
        check("ctrl", rv, 32'h1);
        input_slots <= 16'hFFFF;
        repeat (3) @(posedge aclk);
        m.rd(`DIPIM_OFS_IN_IMAGE, rv, rs);
        check("frozen", rv[15:0], swp(16'h0001));
        m.wr(`DIPIM_OFS_CTRL, 32'h0, rs);
        repeat (3) @(posedge aclk);
        m.rd(`DIPIM_OFS_IN_IMAGE, rv, rs);
        check("refreshed", rv[15:0], 32'hFFFF);
        $display("freeze test done");
        final_report;
    end
endmodule // dipim_top_test
